// file: verilog/fdr_pkg.sv
// Constants for the fan duty ramp and floor block.
// Assumes an APB slave with 32-bit data, one register per word.
package fdr_pkg;
    localparam logic [7:0] RAMP_CTRL_IDX   = 8'h63;
    localparam logic [7:0] FLOOR1_IDX      = 8'h64;
    localparam logic [7:0] FLOOR2_IDX      = 8'h65;
    localparam logic [7:0] FLOOR3_IDX      = 8'h66;
    localparam logic [7:0] MODE_IDX        = 8'h67;
    localparam logic [7:0] TARGET2_IDX     = 8'h68;
    localparam logic [7:0] TARGET3_IDX     = 8'h69;
    localparam logic [7:0] DUTY2_IDX       = 8'h6A;
    localparam logic [7:0] DUTY3_IDX       = 8'h6B;
    localparam logic [7:0] RAMP_CTRL_RST   = 8'h00;
    localparam logic [7:0] FLOOR_RST       = 8'h80;
    localparam logic [7:0] MODE_RST        = 8'h00;
    localparam logic [7:0] TARGET_RST      = 8'h00;
    localparam logic [7:0] DUTY_RST        = 8'h00;
    localparam int RATE3_LSB  = 0;
    localparam int EN3_BIT    = 3;
    localparam int RATE2_LSB  = 4;
    localparam int EN2_BIT    = 7;
    localparam int AUTO_BIT   = 0;
    localparam int HOLD2_BIT  = 1;
    localparam int HOLD3_BIT  = 2;
    localparam int ABOVE2_BIT = 3;
    localparam int ABOVE3_BIT = 4;
    localparam int CLK_HZ     = 50_000_000;
    localparam int SLOT_US    = 1000;
    localparam int SLOT_CYC   = CLK_HZ / 1_000_000 * SLOT_US;
endpackage

// file: verilog/fdr_ramp.sv
// One ramp limiter: moves current duty toward target per time slot.
// Assumes slot_tick is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
module fdr_ramp (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       slot_tick,
    input  wire logic       ramp_en,
    input  wire logic [2:0] rate,
    input  wire logic [7:0] target,
    output logic      [7:0] duty
);
    logic [7:0] duty_q;
    logic [7:0] duty_d;
    logic [7:0] step;
    logic [7:0] diff_up;
    logic [7:0] diff_dn;

    function automatic logic [7:0] rate_step(input logic [2:0] code);
        logic [7:0] s;
        s = 8'h01;
        unique case (code)
            3'h0: s = 8'h01;
            3'h1: s = 8'h02;
            3'h2: s = 8'h03;
            3'h3: s = 8'h05;
            3'h4: s = 8'h08;
            3'h5: s = 8'h0C;
            3'h6: s = 8'h18;
            3'h7: s = 8'h30;
        endcase
        return s;
    endfunction

    assign step    = rate_step(rate);
    assign diff_up = target - duty_q;
    assign diff_dn = duty_q - target;

    always_comb begin
        duty_d = duty_q;
        if (!ramp_en) begin
            duty_d = target;
        end else if (slot_tick && target > duty_q) begin
            duty_d = (diff_up > step) ? duty_q + step : target;
        end else if (slot_tick && target < duty_q) begin
            duty_d = (diff_dn > step) ? duty_q - step : target;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            duty_q <= fdr_pkg::DUTY_RST;
        end else begin
            duty_q <= duty_d;
        end
    end

    assign duty = duty_q;
endmodule

// file: verilog/fdr_top.sv
// Fan duty ramp limiter and floor duty registers with APB slave.
// Assumes APB master on sys_clk; temperature logic outside sets targets.
//
// Functional notes
// - Bits 2:0 set output 3 ramp rate
// - Codes map to steps 1,2,3,5,8,12,24,48
// - Bit 3 enables output 3 ramping
// - Bits 6:4 set output 2 ramp rate
// - Bit 7 enables output 2 ramping
// - Three floor registers, reset to 0x80
// - Floor value scales linearly to duty
// - Floor writes ignored in automatic mode
// - Above start, output runs from floor (outputs 2 and 3 only; output 1 always shows floor 1)
// - Below start, hold floor or zero (outputs 2 and 3 only; output 1 always shows floor 1)
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module fdr_top (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  fan_drive_1,
    output logic      [7:0]  fan_drive_2,
    output logic      [7:0]  fan_drive_3
);
    logic [7:0]  ramp_ctrl_q;
    logic [7:0]  floor_q [3];
    logic [7:0]  mode_q;
    logic [7:0]  target2_q;
    logic [7:0]  target3_q;
    logic [15:0] slot_cnt_q;
    logic        slot_tick;
    logic        wr_en;
    logic        rd_en;
    logic [9:0]  idx;
    logic        hit_ctrl;
    logic        hit_mode;
    logic        hit_tgt2;
    logic        hit_tgt3;
    logic        hit_duty2;
    logic        hit_duty3;
    logic [2:0]  hit_floor;
    logic        auto_mode;
    logic [7:0]  eff2;
    logic [7:0]  eff3;
    logic [7:0]  duty2;
    logic [7:0]  duty3;
    logic [7:0]  rd_byte;

    function automatic logic [7:0] floor_or_target(
        input logic       autom,
        input logic       above,
        input logic       hold,
        input logic [7:0] floor_v,
        input logic [7:0] tgt
    );
        logic [7:0] r;
        r = tgt;
        if (autom) begin
            if (above) begin
                r = (tgt < floor_v) ? floor_v : tgt;
            end else begin
                r = hold ? floor_v : 8'h00;
            end
        end
        return r;
    endfunction

    function automatic logic idx_hit(
        input logic [9:0] a,
        input logic [7:0] reg_idx
    );
        return a == {2'b00, reg_idx};
    endfunction

    assign idx       = paddr[11:2];
    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && !pwrite;
    assign auto_mode = mode_q[fdr_pkg::AUTO_BIT];
    assign pready    = 1'b1;
    assign pslverr   = 1'b0;

    // Address decode
    assign hit_ctrl     = idx_hit(idx, fdr_pkg::RAMP_CTRL_IDX);
    assign hit_floor[0] = idx_hit(idx, fdr_pkg::FLOOR1_IDX);
    assign hit_floor[1] = idx_hit(idx, fdr_pkg::FLOOR2_IDX);
    assign hit_floor[2] = idx_hit(idx, fdr_pkg::FLOOR3_IDX);
    assign hit_mode     = idx_hit(idx, fdr_pkg::MODE_IDX);
    assign hit_tgt2     = idx_hit(idx, fdr_pkg::TARGET2_IDX);
    assign hit_tgt3     = idx_hit(idx, fdr_pkg::TARGET3_IDX);
    assign hit_duty2    = idx_hit(idx, fdr_pkg::DUTY2_IDX);
    assign hit_duty3    = idx_hit(idx, fdr_pkg::DUTY3_IDX);

    // Slot timer for ramp steps
    assign slot_tick = (slot_cnt_q == 16'(fdr_pkg::SLOT_CYC - 1));
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            slot_cnt_q <= 16'h0000;
        end else begin
            slot_cnt_q <= slot_tick ? 16'h0000 : slot_cnt_q + 16'h0001;
        end
    end

    // Control registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ramp_ctrl_q <= fdr_pkg::RAMP_CTRL_RST;
            mode_q      <= fdr_pkg::MODE_RST;
            target2_q   <= fdr_pkg::TARGET_RST;
            target3_q   <= fdr_pkg::TARGET_RST;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                ramp_ctrl_q <= pwdata[7:0];
            end
            if (hit_mode) begin
                mode_q <= {3'h0, pwdata[4:0]};
            end
            if (hit_tgt2) begin
                target2_q <= pwdata[7:0];
            end
            if (hit_tgt3) begin
                target3_q <= pwdata[7:0];
            end
        end
    end

    // Floor duty registers, locked in automatic mode
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_floor
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    floor_q[gi] <= fdr_pkg::FLOOR_RST;
                end else if (wr_en && !auto_mode && hit_floor[gi]) begin
                    floor_q[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // Targets after floor and below-start selection
    assign eff2 = floor_or_target(auto_mode,
        mode_q[fdr_pkg::ABOVE2_BIT], mode_q[fdr_pkg::HOLD2_BIT],
        floor_q[1], target2_q);
    assign eff3 = floor_or_target(auto_mode,
        mode_q[fdr_pkg::ABOVE3_BIT], mode_q[fdr_pkg::HOLD3_BIT],
        floor_q[2], target3_q);

    fdr_ramp u_ramp2 (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .slot_tick (slot_tick),
        .ramp_en   (ramp_ctrl_q[fdr_pkg::EN2_BIT]),
        .rate      (ramp_ctrl_q[fdr_pkg::RATE2_LSB +: 3]),
        .target    (eff2),
        .duty      (duty2)
    );

    fdr_ramp u_ramp3 (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .slot_tick (slot_tick),
        .ramp_en   (ramp_ctrl_q[fdr_pkg::EN3_BIT]),
        .rate      (ramp_ctrl_q[fdr_pkg::RATE3_LSB +: 3]),
        .target    (eff3),
        .duty      (duty3)
    );

    // Duty value is linear 0x00..0xFF, passed out unchanged
    assign fan_drive_1 = floor_q[0];
    assign fan_drive_2 = duty2;
    assign fan_drive_3 = duty3;

    // Read mux, unmapped reads give zero
    assign rd_byte = ({8{hit_ctrl}}     & ramp_ctrl_q)
                   | ({8{hit_floor[0]}} & floor_q[0])
                   | ({8{hit_floor[1]}} & floor_q[1])
                   | ({8{hit_floor[2]}} & floor_q[2])
                   | ({8{hit_mode}}     & mode_q)
                   | ({8{hit_tgt2}}     & target2_q)
                   | ({8{hit_tgt3}}     & target3_q)
                   | ({8{hit_duty2}}    & duty2)
                   | ({8{hit_duty3}}    & duty3);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            prdata <= {24'h000000, rd_byte};
        end
    end
endmodule

// file: dv/fdr_top_monitor.sv
// Checker for the fan duty ramp and floor block.
// Sees only the ports of fdr_top; bound in at the foot.
`timescale 1ns/1ps
module fdr_top_monitor (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  fan_drive_1,
    input wire logic [7:0]  fan_drive_2,
    input wire logic [7:0]  fan_drive_3
);
    localparam logic [7:0] STP [8] = '{8'h01, 8'h02, 8'h03, 8'h05,
                                       8'h08, 8'h0C, 8'h18, 8'h30};
    logic [7:0]  ctl_q;
    logic [7:0]  t2_q;
    logic [7:0]  t3_q;
    logic        aut_q;
    logic [15:0] gap_q;
    wire         acc = psel && penable && pwrite && pready;
    wire         wf1 = acc && paddr == 12'h190;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Shadow of the registers the checks depend on
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= 8'h00;
            aut_q <= 1'b0;
            t2_q <= 8'h00;
            t3_q <= 8'h00;
        end else if (acc) begin
            if (paddr == 12'h18C) ctl_q <= pwdata[7:0];
            if (paddr == 12'h19C) aut_q <= pwdata[0];
            if (paddr == 12'h1A0) t2_q <= pwdata[7:0];
            if (paddr == 12'h1A4) t3_q <= pwdata[7:0];
        end
    end
    // Cycles since output 2 last moved while ramping
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) gap_q <= 16'hFFFF;
        else if (!ctl_q[7]) gap_q <= 16'hFFFF;
        else if ($changed(fan_drive_2)) gap_q <= 16'h0000;
        else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
    end
    sequence wr_t2;
        acc && paddr == 12'h1A0 && !aut_q && !ctl_q[7];
    endsequence
    sequence wr_t3;
        acc && paddr == 12'h1A4 && !aut_q && !ctl_q[3];
    endsequence
    property lim(logic en, logic [2:0] c, logic [7:0] d);
        $past(en) && $changed(d) |->
            (d > $past(d) ? d - $past(d) : $past(d) - d) <= STP[$past(c)];
    endproperty
    floor_load_a: assert property (
        wf1 && !aut_q |=> fan_drive_1 == $past(pwdata[7:0]))
        else $error("floor write not shown on output 1");
    floor_lock_a: assert property (
        wf1 && aut_q |=> $stable(fan_drive_1))
        else $error("floor write taken in automatic mode");
    floor_cause_a: assert property (
        $changed(fan_drive_1) |-> $past(wf1 && !aut_q))
        else $error("output 1 moved without a floor write");
    step_lim2_a: assert property (lim(ctl_q[7], ctl_q[6:4], fan_drive_2))
        else $error("output 2 step too large");
    step_lim3_a: assert property (lim(ctl_q[3], ctl_q[2:0], fan_drive_3))
        else $error("output 3 step too large");
    slot_gap_a: assert property (
        ctl_q[7] && $changed(fan_drive_2) |-> gap_q >= 16'hC34F)
        else $error("output 2 stepped twice in one slot");
    direct_two_a: assert property (
        wr_t2 |-> ##[1:2] fan_drive_2 == t2_q)
        else $error("output 2 not updated directly");
    direct_three_a: assert property (
        wr_t3 |-> ##[1:2] fan_drive_3 == t3_q)
        else $error("output 3 not updated directly");
endmodule
bind fdr_top fdr_top_monitor fdr_top_monitor_inst (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fan_drive_1(fan_drive_1),
    .fan_drive_2(fan_drive_2), .fan_drive_3(fan_drive_3));

// file: dv/fdr_fan_model.sv
// Behavioural fan on one duty output; reports each duty change size.
// Assumes the duty output is settled at each sys_clk rising edge.
`timescale 1ns/1ps
module fdr_fan_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] drive,
    output logic      [7:0] step
);
    logic [7:0] last_q = 8'h00;
    always @(posedge sys_clk) begin
        if (drive != last_q) begin
            step <= drive > last_q ? drive - last_q : last_q - drive;
        end
        last_q <= drive;
    end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the fan duty ramp and floor block.
// Assumes fdr_top with its bound checker and a fan model on output 2.
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic [7:0]  fd1, fd2, fd3, st2;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    always #10 sys_clk = ~sys_clk;
    fdr_top fdr_top_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(), .fan_drive_1(fd1),
        .fan_drive_2(fd2), .fan_drive_3(fd3));
    fdr_fan_model fdr_fan_model_inst (.sys_clk(sys_clk), .drive(fd2),
        .step(st2));
    task automatic print_verdict;
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] i,
                       input logic [7:0] d, output logic [7:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] x;
        apb(1'b1, i, d, x);
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] x;
        apb(1'b0, i, 8'h00, x);
        chk(x, e);
    endtask
    task automatic t_reset;
        rdc(8'h63, 8'h00);
        rdc(8'h64, 8'h80);
        rdc(8'h66, 8'h80);
        rdc(8'h65, 8'h80);
        chk(fd1, 8'h80);
        chk(fd2, 8'h00);
    endtask
    task automatic t_floor;
        logic [7:0] v [3] = '{8'h40, 8'hFF, 8'h00};
        foreach (v[i]) begin
            wr(8'h64, v[i]);
            chk(fd1, v[i]);
            rdc(8'h64, v[i]);
        end
        wr(8'h65, 8'h40);
        wr(8'h66, 8'hFF);
    endtask
    task automatic t_lock;
        wr(8'h67, 8'h01);
        wr(8'h64, 8'h11);
        wr(8'h65, 8'h22);
        rdc(8'h64, 8'h00);
        rdc(8'h65, 8'h40);
        chk(fd1, 8'h00);
    endtask
    task automatic t_auto;
        wr(8'h67, 8'h07);
        chk(fd2, 8'h40);
        chk(fd3, 8'hFF);
        wr(8'h67, 8'h01);
        chk(fd2, 8'h00);
        wr(8'h68, 8'h90);
        wr(8'h69, 8'h10);
        wr(8'h67, 8'h19);
        chk(fd2, 8'h90);
        chk(fd3, 8'hFF);
    endtask
    task automatic t_direct;
        wr(8'h67, 8'h00);
        wr(8'h68, 8'hC0);
        wr(8'h69, 8'h05);
        chk(fd2, 8'hC0);
        chk(fd3, 8'h05);
    endtask
    task automatic t_ramp;
        int n;
        n = 0;
        wr(8'h63, 8'hF8);
        rdc(8'h63, 8'hF8);
        wr(8'h69, 8'hFF);
        wr(8'h68, 8'h00);
        while (fd2 === 8'hC0 && n < 60000) begin
            n++;
            @(posedge sys_clk);
        end
        @(posedge sys_clk);
        chk(fd2, 8'h90);
        chk(st2, 8'h30);
        chk(fd3, 8'h06);
        rdc(8'h6A, 8'h90);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            print_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_reset;
        t_floor;
        t_lock;
        t_auto;
        t_direct;
        t_ramp;
        print_verdict;
    end
endmodule
